//--- hdl/dmm_monitor.sv
/*
 * Drive motion monitor: parameter registers at fieldbus addresses, four
 * window-qualified comparisons, an input-driven speed limit, a routable
 * status output and the start-up notice word.
 * Assumes measured values come from logic on core_clk; the limit request is
 * an asynchronous pin. The register port is a simple one-access-per-pulse port.
 */
//
// Behaviour
// - Current below current threshold for the check window raises current status.
// - Speed deviation below its window value for the check window raises in-speed status.
// - Active limit input clamps the speed command to the input speed limit, 1..9999.
// - Speed below speed threshold for the check window raises speed-threshold status.
// - Position deviation below window value for the check window raises in-position status.
// - One common check window time in milliseconds, 0..9999, qualifies all four results.
// - Start-up word bits 0..4 report setup, motor change, bad storage, no motor, restart.
// - Writing one to bits 0, 1, 4 acknowledges those start-up conditions.
`timescale 1ns/1ps
`include "dmm_map.svh"
module dmm_monitor #(
   parameter int CYC_PER_MS = `DMM_CYC_PER_MS
) (
   input  wire logic               core_clk,
   input  wire logic               nrst,
   input  wire logic               reg_rd,
   input  wire logic               reg_wr,
   input  wire dmm_pkg::dmm_addr_t reg_addr,
   input  wire dmm_pkg::dmm_word_t reg_wdata,
   output dmm_pkg::dmm_word_t      reg_rdata,
   output logic                    reg_ack,
   output logic                    reg_err,
   input  wire logic [15:0]        current_act,
   input  wire logic [15:0]        speed_dev_act,
   input  wire logic [15:0]        speed_act,
   input  wire logic [15:0]        pos_dev_act,
   input  wire logic signed [15:0] speed_cmd,
   input  wire logic               limit_pin,
   input  wire logic               first_setup_evt,
   input  wire logic               motor_changed_evt,
   input  wire logic               nvm_corrupt,
   input  wire logic               no_motor,
   input  wire logic               restart_param_evt,
   output logic signed [15:0]      speed_cmd_limited,
   output logic                    speed_limit_active,
   output logic [3:0]              window_status,
   output logic                    prog_out
);
   import dmm_pkg::*;

   logic [1:0]  rst_sync;
   logic        rst_n;
   logic [1:0]  limit_sync;
   logic [31:0] ms_count;
   logic        ms_tick;
   dmm_param_t  position_window_deviation;
   dmm_param_t  speed_window_deviation;
   dmm_param_t  speed_threshold_level;
   dmm_param_t  current_threshold_level;
   dmm_param_t  check_window_time;
   dmm_param_t  input_speed_limit;
   logic [1:0]  out_sel;
   logic [4:0]  startup_flags;
   logic [3:0]  win_status;

   // Reset is asserted at once but released through two flip-flops.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // The limit pin is asynchronous; only the second stage is read.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         limit_sync <= 2'h0;
      end else begin
         limit_sync <= {limit_sync[0], limit_pin};
      end
   end

   // Millisecond prescaler shared by all window qualifiers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ms_count <= 32'h0;
         ms_tick  <= 1'b0;
      end else if (ms_count >= 32'(CYC_PER_MS - 1)) begin
         ms_count <= 32'h0;
         ms_tick  <= 1'b1;
      end else begin
         ms_count <= ms_count + 32'h1;
         ms_tick  <= 1'b0;
      end
   end

   // Register decode and write legality.
   wire sel_startup  = reg_addr == `DMM_ADDR_STARTUP;
   wire sel_pos_win  = reg_addr == `DMM_ADDR_POS_WIN;
   wire sel_spd_win  = reg_addr == `DMM_ADDR_SPD_WIN;
   wire sel_spd_thr  = reg_addr == `DMM_ADDR_SPD_THR;
   wire sel_cur_thr  = reg_addr == `DMM_ADDR_CUR_THR;
   wire sel_win_time = reg_addr == `DMM_ADDR_WIN_TIME;
   wire sel_spd_lim  = reg_addr == `DMM_ADDR_SPD_LIM;
   wire sel_out_sel  = reg_addr == `DMM_ADDR_OUT_SEL;
   wire sel_status   = reg_addr == `DMM_ADDR_STATUS;
   wire sel_param    = sel_pos_win | sel_spd_win | sel_spd_thr | sel_cur_thr | sel_win_time | sel_spd_lim;
   wire sel_any      = sel_param | sel_startup | sel_out_sel | sel_status;
   // A parameter above 9999, or a speed limit of zero, is refused unchanged.
   wire over_range   = reg_wdata[31:0] > {16'h0, `DMM_PARAM_MAX};
   wire lim_low      = sel_spd_lim && (reg_wdata[15:0] < `DMM_SPD_LIM_MIN);
   wire wr_bad       = reg_wr && ((sel_param && (over_range || lim_low)) || sel_status);
   wire wr_ok        = reg_wr && sel_any && !wr_bad;
   wire acc_err      = (reg_rd || reg_wr) && (!sel_any || wr_bad);

   // Parameter registers; only legal writes land.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         position_window_deviation <= `DMM_RST_POS_WIN;
         speed_window_deviation    <= `DMM_RST_SPD_WIN;
         speed_threshold_level     <= `DMM_RST_SPD_THR;
         current_threshold_level   <= `DMM_RST_CUR_THR;
         check_window_time         <= `DMM_RST_WIN_TIME;
         input_speed_limit         <= `DMM_RST_SPD_LIM;
         out_sel                   <= `DMM_RST_OUT_SEL;
      end else if (wr_ok) begin
         if (sel_pos_win)  position_window_deviation <= reg_wdata[15:0];
         if (sel_spd_win)  speed_window_deviation    <= reg_wdata[15:0];
         if (sel_spd_thr)  speed_threshold_level     <= reg_wdata[15:0];
         if (sel_cur_thr)  current_threshold_level   <= reg_wdata[15:0];
         if (sel_win_time) check_window_time         <= reg_wdata[15:0];
         if (sel_spd_lim)  input_speed_limit         <= reg_wdata[15:0];
         if (sel_out_sel)  out_sel                   <= reg_wdata[1:0];
      end
   end

   // Start-up flags: events set bits 0, 1, 4 and write-one clears them; bits 2, 3 follow their inputs; a set in the clearing cycle wins.
   wire       su_wr = wr_ok && sel_startup;
   wire [4:0] su_set = {restart_param_evt, 2'h0, motor_changed_evt, first_setup_evt};
   wire [4:0] su_clr = su_wr ? {reg_wdata[`DMM_SU_RESTART_PARAM], 2'h0,
                                reg_wdata[`DMM_SU_MOTOR_CHANGED], reg_wdata[`DMM_SU_FIRST_SETUP]} : 5'h0;
   wire [4:0] next_su_sticky = su_set | (startup_flags & ~su_clr);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         startup_flags <= 5'h0;
      end else begin
         startup_flags[`DMM_SU_FIRST_SETUP]   <= next_su_sticky[`DMM_SU_FIRST_SETUP];
         startup_flags[`DMM_SU_MOTOR_CHANGED] <= next_su_sticky[`DMM_SU_MOTOR_CHANGED];
         startup_flags[`DMM_SU_NVM_CORRUPT]   <= nvm_corrupt;
         startup_flags[`DMM_SU_NO_MOTOR]      <= no_motor;
         startup_flags[`DMM_SU_RESTART_PARAM] <= next_su_sticky[`DMM_SU_RESTART_PARAM];
      end
   end

   // Read data selection.
   wire [31:0] rd_mux =
      sel_startup  ? {27'h0, startup_flags} :
      sel_pos_win  ? {16'h0, position_window_deviation} :
      sel_spd_win  ? {16'h0, speed_window_deviation} :
      sel_spd_thr  ? {16'h0, speed_threshold_level} :
      sel_cur_thr  ? {16'h0, current_threshold_level} :
      sel_win_time ? {16'h0, check_window_time} :
      sel_spd_lim  ? {16'h0, input_speed_limit} :
      sel_out_sel  ? {30'h0, out_sel} :
      sel_status   ? {27'h0, limit_sync[1], win_status} : 32'h0;

   // Every access is answered one cycle later; errors read as zero.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0;
         reg_ack   <= 1'b0;
         reg_err   <= 1'b0;
      end else begin
         reg_rdata <= (reg_rd && sel_any) ? rd_mux : 32'h0;
         reg_ack   <= reg_rd || reg_wr;
         reg_err   <= acc_err;
      end
   end

   // Comparisons of each measured quantity against its limit, strictly below.
   wire [3:0] in_range;
   assign in_range[DMM_CH_POSITION]  = pos_dev_act   < position_window_deviation;
   assign in_range[DMM_CH_SPEED_DEV] = speed_dev_act < speed_window_deviation;
   assign in_range[DMM_CH_SPEED]     = speed_act     < speed_threshold_level;
   assign in_range[DMM_CH_CURRENT]   = current_act   < current_threshold_level;

   // One qualifier per quantity, all sharing the check window time.
   for (genvar ch = 0; ch < DMM_NUM_CH; ch++) begin : g_win
      dmm_win_if wif ();
      assign wif.ms_tick    = ms_tick;
      assign wif.window_ms  = check_window_time;
      assign wif.in_range   = in_range[ch];
      assign win_status[ch] = wif.status;
      dmm_window u_win (
         .core_clk (core_clk),
         .rst_n    (rst_n),
         .win      (wif.qual)
      );
   end

   // Speed clamp: magnitude limited symmetrically while the limit input is active.
   wire signed [16:0] lim_pos = {1'b0, input_speed_limit};
   wire signed [16:0] lim_neg = -lim_pos;
   wire signed [16:0] cmd_ext = {speed_cmd[15], speed_cmd};
   wire signed [16:0] cmd_clamped = (cmd_ext > lim_pos) ? lim_pos :
                                    (cmd_ext < lim_neg) ? lim_neg : cmd_ext;

   // Outputs are registered; the routed output follows the selected status.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         speed_cmd_limited  <= 16'sh0;
         speed_limit_active <= 1'b0;
         window_status      <= 4'h0;
         prog_out           <= 1'b0;
      end else begin
         speed_limit_active <= limit_sync[1];
         speed_cmd_limited  <= limit_sync[1] ? cmd_clamped[15:0] : speed_cmd;
         window_status      <= win_status;
         prog_out           <= win_status[out_sel];
      end
   end
endmodule

//--- hdl/dmm_window.sv
/*
 * Window qualifier: raises its status once its condition has held for the
 * whole check window and drops it at once when the condition fails.
 * Assumes an active-low reset, asserted asynchronously, and a millisecond tick
 * on core_clk.
 */
`timescale 1ns/1ps
module dmm_window (
   input  wire logic core_clk,
   input  wire logic rst_n,
   dmm_win_if.qual   win
);
   logic [15:0] elapsed_ms;
   logic        window_done;

   // A tick may fall in the first cycle in range, so the first counted
   // millisecond can be nearly empty. One tick beyond the window is therefore
   // needed, and the condition has always held for the full window; a prescaler
   // per channel is traded for a shared tick. A zero window needs no tick.
   assign window_done = (win.window_ms == 16'h0000) || (elapsed_ms > win.window_ms);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         elapsed_ms <= '0;
         win.status <= 1'b0;
      end else if (!win.in_range) begin
         elapsed_ms <= '0;
         win.status <= 1'b0;
      end else if (window_done) begin
         win.status <= 1'b1;
      end else if (win.ms_tick) begin
         elapsed_ms <= elapsed_ms + 16'h0001;
      end
   end
endmodule

//--- include/dmm_map.svh
/*
 * Register addresses, field positions, reset values and timing figures of the
 * drive motion monitor. Included by the design and bench files; holds
 * definitions only.
 */
`ifndef DMM_MAP_SVH
`define DMM_MAP_SVH

// Register addresses as seen by the fieldbus master (word addresses).
`define DMM_ADDR_STARTUP      16'h0138
`define DMM_ADDR_POS_WIN      16'h0632
`define DMM_ADDR_SPD_WIN      16'h0634
`define DMM_ADDR_SPD_THR      16'h0636
`define DMM_ADDR_CUR_THR      16'h0638
`define DMM_ADDR_WIN_TIME     16'h063a
`define DMM_ADDR_SPD_LIM      16'h063c
`define DMM_ADDR_OUT_SEL      16'h0640
`define DMM_ADDR_STATUS       16'h0642

// Reset values of the parameter registers.
`define DMM_RST_POS_WIN       16'h000a
`define DMM_RST_SPD_WIN       16'h0000
`define DMM_RST_SPD_THR       16'h0000
`define DMM_RST_CUR_THR       16'h0000
`define DMM_RST_WIN_TIME      16'h0000
`define DMM_RST_SPD_LIM       16'h000a
`define DMM_RST_OUT_SEL       2'h0

// Legal value range of the parameters.
`define DMM_PARAM_MAX         16'h270f
`define DMM_SPD_LIM_MIN       16'h0001

// Start-up notice word bit positions.
`define DMM_SU_FIRST_SETUP    0
`define DMM_SU_MOTOR_CHANGED  1
`define DMM_SU_NVM_CORRUPT    2
`define DMM_SU_NO_MOTOR       3
`define DMM_SU_RESTART_PARAM  4

// Timing: one millisecond at a 25 ns clock period.
`define DMM_MS_NS             1000000
`define DMM_CLK_PERIOD_NS     25
`define DMM_CYC_PER_MS        (`DMM_MS_NS / `DMM_CLK_PERIOD_NS)

`endif

//--- include/dmm_pkg.sv
/*
 * Types shared by the drive motion monitor files.
 * Assumes dmm_map.svh is on the include path.
 */
package dmm_pkg;
   typedef logic [15:0] dmm_addr_t;
   typedef logic [15:0] dmm_param_t;
   typedef logic [31:0] dmm_word_t;

   // Monitored quantities, also the index of each window status bit.
   typedef enum logic [1:0] {
      DMM_CH_POSITION,
      DMM_CH_SPEED_DEV,
      DMM_CH_SPEED,
      DMM_CH_CURRENT
   } dmm_chan_e;

   localparam int DMM_NUM_CH = 4;
endpackage

//--- include/dmm_win_if.sv
/*
 * Carrier between the monitor top and one window qualifier.
 * Assumes one instance per monitored quantity, all on core_clk.
 */
`timescale 1ns/1ps
interface dmm_win_if;
   logic        ms_tick;   // One-cycle pulse every millisecond.
   logic [15:0] window_ms; // Check window time in milliseconds.
   logic        in_range;  // Quantity is below its limit this cycle.
   logic        status;    // Qualified window status.

   modport ctrl (output ms_tick, output window_ms, output in_range, input status);
   modport qual (input ms_tick, input window_ms, input in_range, output status);
endinterface

//--- testbench/dmm_master_model.sv
/*
 * Fieldbus master model for the monitor's register port.
 * Assumes one pulse per access and an answer exactly one cycle later.
 */
`timescale 1ns/1ps
`include "dmm_map.svh"
module dmm_master_model (
   input  wire logic               core_clk,
   output logic                    reg_rd,
   output logic                    reg_wr,
   output dmm_pkg::dmm_addr_t      reg_addr,
   output dmm_pkg::dmm_word_t      reg_wdata,
   input  wire dmm_pkg::dmm_word_t reg_rdata,
   input  wire logic               reg_ack,
   input  wire logic               reg_err
);
   import dmm_pkg::*;

   // Idle bus at time zero.
   initial begin
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
   end

   // Released address and data are inverted so a stale value never looks valid.
   task automatic acc(input logic wr, input dmm_addr_t a, input dmm_word_t d,
                      output dmm_word_t q, output logic k, output logic e);
      reg_rd <= ~wr;
      reg_wr <= wr;
      reg_addr <= a;
      reg_wdata <= (a == `DMM_ADDR_STARTUP) ? (d & 32'h0000_0013) : d;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      @(posedge core_clk);
      q = reg_rdata;
      k = reg_ack;
      e = reg_err;
   endtask
endmodule

//--- testbench/dmm_monitor_assertions.sv
/*
 * Checker for the monitor top ports.
 * Assumes a value of 0xffff is above every legal limit.
 */
`timescale 1ns/1ps
`include "dmm_map.svh"
module dmm_monitor_assertions #(
   parameter int CYC_PER_MS = 4
) (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        reg_rd,
   input wire logic        reg_wr,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        reg_ack,
   input wire logic        reg_err,
   input wire logic [15:0] current_act,
   input wire logic [15:0] speed_dev_act,
   input wire logic [15:0] speed_act,
   input wire logic [15:0] pos_dev_act,
   input wire logic        limit_pin,
   input wire logic        nvm_corrupt,
   input wire logic        no_motor,
   input wire logic        speed_limit_active,
   input wire logic [3:0]  window_status
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // A request and its one-cycle answer.
   sequence s_req; reg_rd || reg_wr; endsequence
   sequence s_ans; reg_ack; endsequence

   a_ack_one_cycle:
      assert property (s_req |=> s_ans) else $error("Access not answered after one cycle.");
   a_cur_clear:
      assert property (current_act == 16'hffff |-> ##2 !window_status[3]) else $error("Current status held.");
   a_dev_clear:
      assert property (speed_dev_act == 16'hffff |-> ##2 !window_status[1]) else $error("Deviation status held.");
   a_spd_clear:
      assert property (speed_act == 16'hffff |-> ##2 !window_status[2]) else $error("Speed status held.");
   a_pos_clear:
      assert property (pos_dev_act == 16'hffff |-> ##2 !window_status[0]) else $error("Position status held.");
   a_limit_sync:
      assert property ($rose(speed_limit_active) |-> $past(limit_pin, 3) && !$past(limit_pin, 4))
         else $error("Limit activation at the wrong edge.");
   a_lim_zero:
      assert property (reg_wr && reg_addr == `DMM_ADDR_SPD_LIM && reg_wdata == 32'h0 |=> reg_err)
         else $error("Zero speed limit accepted.");
   a_win_range:
      assert property (reg_wr && reg_addr == `DMM_ADDR_WIN_TIME
         |=> reg_err == ($past(reg_wdata) > {16'h0, `DMM_PARAM_MAX})) else $error("Window time range wrong.");
   a_su_levels:
      assert property (reg_rd && reg_addr == `DMM_ADDR_STARTUP && $stable(nvm_corrupt) && $stable(no_motor)
         |=> reg_rdata[3:2] == {$past(no_motor), $past(nvm_corrupt)}) else $error("Start-up level bits wrong.");
endmodule

bind dmm_monitor dmm_monitor_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
   .core_clk(core_clk), .nrst(nrst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
   .current_act(current_act), .speed_dev_act(speed_dev_act), .speed_act(speed_act),
   .pos_dev_act(pos_dev_act), .limit_pin(limit_pin), .nvm_corrupt(nvm_corrupt), .no_motor(no_motor),
   .speed_limit_active(speed_limit_active), .window_status(window_status));

//--- testbench/testbench.sv
/*
 * Self-checking bench for the drive motion monitor.
 * Assumes the master model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`include "dmm_map.svh"
module testbench;
   import dmm_pkg::*;
   localparam int CPM = 4;
   logic               core_clk = 1'b0;
   logic               nrst = 1'b0;
   logic               reg_rd, reg_wr, reg_ack, reg_err, k, e;
   dmm_addr_t          reg_addr;
   dmm_word_t          reg_wdata, reg_rdata, q;
   logic [15:0]        act [4] = '{default: 16'hffff};
   logic signed [15:0] speed_cmd = 16'sh0;
   logic signed [15:0] speed_cmd_limited;
   logic               limit_pin = 1'b0, nvm_corrupt = 1'b0, no_motor = 1'b0;
   logic               first_setup_evt = 1'b0, motor_changed_evt = 1'b0, restart_param_evt = 1'b0;
   logic               speed_limit_active, prog_out;
   logic [3:0]         window_status;
   int                 miscompares = 0;
   int                 num_checks = 0;
   dmm_addr_t          adr [6] = '{16'h0632, 16'h0634, 16'h0636, 16'h0638, 16'h063a, 16'h063c};

   initial forever #12.5 core_clk = ~core_clk;

   dmm_master_model m (.core_clk(core_clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err));

   dmm_monitor #(.CYC_PER_MS(CPM)) dut (.core_clk(core_clk), .nrst(nrst), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_err(reg_err), .current_act(act[3]), .speed_dev_act(act[1]),
      .speed_act(act[2]), .pos_dev_act(act[0]), .speed_cmd(speed_cmd), .limit_pin(limit_pin),
      .first_setup_evt(first_setup_evt), .motor_changed_evt(motor_changed_evt), .nvm_corrupt(nvm_corrupt),
      .no_motor(no_motor), .restart_param_evt(restart_param_evt), .speed_cmd_limited(speed_cmd_limited),
      .speed_limit_active(speed_limit_active), .window_status(window_status), .prog_out(prog_out));

   task automatic chk(input string n, input dmm_word_t seen, input dmm_word_t exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // Every access must be answered; the error flag is compared with the expected one.
   task automatic wr(input dmm_addr_t a, input dmm_word_t d, input logic x);
      m.acc(1'b1, a, d, q, k, e);
      chk("ack", {31'h0, k}, 32'h1);
      chk("err", {31'h0, e}, {31'h0, x});
   endtask

   task automatic rd(input dmm_addr_t a, input dmm_word_t exp, input logic x);
      m.acc(1'b0, a, 32'h0, q, k, e);
      chk("ack", {31'h0, k}, 32'h1);
      chk("err", {31'h0, e}, {31'h0, x});
      chk("rdata", q, exp);
   endtask

   task automatic give_verdict;
      if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // The run is a few hundred cycles; this bound only catches a hang.
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      give_verdict;
   end

   initial begin
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(`DMM_ADDR_POS_WIN, 32'ha, 1'b0);
      rd(`DMM_ADDR_CUR_THR, 32'h0, 1'b0);
      rd(`DMM_ADDR_SPD_LIM, 32'ha, 1'b0);
      rd(`DMM_ADDR_WIN_TIME, 32'h0, 1'b0);
      rd(16'h0700, 32'h0, 1'b1);
      wr(`DMM_ADDR_STATUS, 32'h1, 1'b1);
      // Top of range accepted, one above refused and not stored.
      for (int i = 0; i < 6; i++) begin
         wr(adr[i], 32'h270f, 1'b0);
         wr(adr[i], 32'h2710, 1'b1);
         rd(adr[i], 32'h270f, 1'b0);
      end
      wr(`DMM_ADDR_SPD_LIM, 32'h0, 1'b1);
      // Each channel: limit 100, window 2 ms; 99 qualifies, 100 sits on the limit and fails.
      wr(`DMM_ADDR_WIN_TIME, 32'h2, 1'b0);
      for (int c = 0; c < 4; c++) begin
         wr(adr[c], 32'h64, 1'b0);
         wr(`DMM_ADDR_OUT_SEL, c, 1'b0);
         act[c] <= 16'h0063;
         repeat (2 * CPM) @(posedge core_clk);
         chk("early", {31'h0, window_status[c]}, 32'h0);
         repeat (4 * CPM) @(posedge core_clk);
         chk("status", {28'h0, window_status}, 32'h1 << c);
         chk("prog_out", {31'h0, prog_out}, 32'h1);
         act[c] <= 16'h0064;
         repeat (3) @(posedge core_clk);
         chk("drop", {28'h0, window_status}, 32'h0);
      end
      // Limit input clamps both signs, then releases.
      wr(`DMM_ADDR_SPD_LIM, 32'h64, 1'b0);
      speed_cmd <= 16'sd500;
      limit_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("clamp_pos", {16'h0, speed_cmd_limited}, 32'h0064);
      chk("limit_on", {31'h0, speed_limit_active}, 32'h1);
      speed_cmd <= -16'sd500;
      repeat (3) @(posedge core_clk);
      chk("clamp_neg", {16'h0, speed_cmd_limited}, 32'hff9c);
      rd(`DMM_ADDR_STATUS, 32'h10, 1'b0);
      limit_pin <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk("free", {16'h0, speed_cmd_limited}, 32'hfe0c);
      chk("limit_off", {31'h0, speed_limit_active}, 32'h0);
      // Start-up word: sticky events, mirrored levels, write-one validation.
      nvm_corrupt <= 1'b1;
      first_setup_evt <= 1'b1;
      motor_changed_evt <= 1'b1;
      restart_param_evt <= 1'b1;
      @(posedge core_clk);
      first_setup_evt <= 1'b0;
      motor_changed_evt <= 1'b0;
      restart_param_evt <= 1'b0;
      repeat (2) @(posedge core_clk);
      rd(`DMM_ADDR_STARTUP, 32'h17, 1'b0);
      // An event held through the write-one cycle and the cycle after it leaves bit 0 set.
      first_setup_evt <= 1'b1;
      wr(`DMM_ADDR_STARTUP, 32'h13, 1'b0);
      first_setup_evt <= 1'b0;
      rd(`DMM_ADDR_STARTUP, 32'h05, 1'b0);
      wr(`DMM_ADDR_STARTUP, 32'h01, 1'b0);
      rd(`DMM_ADDR_STARTUP, 32'h04, 1'b0);
      nvm_corrupt <= 1'b0;
      no_motor <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(`DMM_ADDR_STARTUP, 32'h08, 1'b0);
      give_verdict;
   end
endmodule
